// >>> src/mbd_defines.vh
// Behaviour
// - two separate request ports, one acting as bus client, one as bus server
// - server port and client engine run concurrently, neither stalls the other
// - server port reaches only the local register store, never the client bus
// - server port answers only its configured id, valid from 1 to 246
// - client-bus id 1 is the internal radio
// - client-bus id 199 is the internal local register store
// - client-bus id 201 is the display board with readable writable indicators
// - base board id is selectable between 200 and 203
// - each device has a unique id; the engine addresses devices by id only
// - radio relays client-bus requests whose id lies in the wireless window
// - window start register at 6502, reset value 11
// - window size register at 6503, writes limited to 100
// - one engine issues every client transaction, internal targets included
// - timeout runs from end of request send until response arrives
// - on timeout the request is dropped and the engine moves on
// - a missing server holds the engine for the full timeout
// - timeout is configurable, reset value 5 seconds
// - radio retry register at 6012, reset value 8
`ifndef MBD_DEFINES_VH
`define MBD_DEFINES_VH
`define MBD_ID_RADIO 8'h01
`define MBD_ID_LOCAL 8'hC7
`define MBD_ID_BASE_A 8'hC8
`define MBD_ID_BASE_B 8'hCB
`define MBD_ID_LCD 8'hC9
`define MBD_SRV_ID_MIN 8'h01
`define MBD_SRV_ID_MAX 8'hF6
`define MBD_REG_WIN_START 16'h1966
`define MBD_REG_WIN_COUNT 16'h1967
`define MBD_REG_RETRY 16'h177C
`define MBD_WIN_START_RST 16'h000B
`define MBD_WIN_COUNT_RST 16'h0032
`define MBD_WIN_COUNT_MAX 16'h0064
`define MBD_RETRY_RST 16'h0008
`define MBD_LED_FIRST 16'h044E
`define MBD_LED_LAST 16'h0456
`define MBD_CLK_PERIOD_NS 40
`define MBD_MS_NS 1000000
`define MBD_MS_CYCLES (`MBD_MS_NS / `MBD_CLK_PERIOD_NS)
`define MBD_TMO_RST_S 5
`define MBD_TMO_RST_MS (`MBD_TMO_RST_S * 1000)
`endif

// >>> src/mbd_regstore.v
`timescale 1ns/100ps
module mbd_regstore (
	input wire clk_i,
	input wire a_en_i,
	input wire a_we_i,
	input wire [7:0] a_addr_i,
	input wire [15:0] a_wdata_i,
	output reg [15:0] a_rdata_o,
	input wire b_en_i,
	input wire b_we_i,
	input wire [7:0] b_addr_i,
	input wire [15:0] b_wdata_i,
	output reg [15:0] b_rdata_o
);
	reg [15:0] mem [0:255];
	integer i;
	initial begin
		for (i = 0; i < 256; i = i + 1) begin
			mem[i] = 16'h0000;
		end
	end
	// two independent ports; engine port wins a same-address write clash
	always @(posedge clk_i) begin
		if (a_en_i && a_we_i && !(b_en_i && b_we_i && b_addr_i == a_addr_i)) begin
			mem[a_addr_i] <= a_wdata_i;
		end
		if (b_en_i && b_we_i) begin
			mem[b_addr_i] <= b_wdata_i;
		end
		if (a_en_i) begin
			a_rdata_o <= mem[a_addr_i];
		end
		if (b_en_i) begin
			b_rdata_o <= mem[b_addr_i];
		end
	end
endmodule

// >>> src/mbd_timeout.v
`timescale 1ns/100ps
module mbd_timeout #(
	parameter MS_CYCLES = 25000
) (
	input wire clk_i,
	input wire nrst_i,
	input wire start_i,
	input wire run_i,
	input wire [15:0] limit_ms_i,
	output wire expired_o
);
	reg [31:0] div_q;
	reg [15:0] ms_q;
	wire tick;
	assign tick = (div_q == MS_CYCLES - 1);
	assign expired_o = run_i && (ms_q >= limit_ms_i);
	// millisecond count restarts at the end of each send
	always @(posedge clk_i) begin
		if (!nrst_i || start_i) begin
			div_q <= 32'h00000000;
			ms_q <= 16'h0000;
		end else if (run_i && !expired_o) begin
			if (tick) begin
				div_q <= 32'h00000000;
				ms_q <= ms_q + 16'h0001;
			end else begin
				div_q <= div_q + 32'h00000001;
			end
		end
	end
endmodule

// >>> src/mbd_top.v
`timescale 1ns/100ps
`include "mbd_defines.vh"
module mbd_top #(
	parameter MS_CYCLES = `MBD_MS_CYCLES
) (
	input wire CORE_CLK_I,
	input wire NRST_I,
	input wire [7:0] HOST_FACING_SERVER_ID_I,
	input wire BASE_ID_SEL_I,
	input wire TMO_LOAD_I,
	input wire [15:0] TMO_MS_I,
	output wire [15:0] TMO_MS_O,
	input wire CMD_VALID_I,
	output wire CMD_READY_O,
	input wire [7:0] CMD_ID_I,
	input wire CMD_WRITE_I,
	input wire [15:0] CMD_ADDR_I,
	input wire [15:0] CMD_DATA_I,
	output wire RSP_VALID_O,
	output wire RSP_TIMEOUT_O,
	output wire [15:0] RSP_DATA_O,
	output wire CTX_VALID_O,
	output wire [7:0] CTX_ID_O,
	output wire CTX_WRITE_O,
	output wire [15:0] CTX_ADDR_O,
	output wire [15:0] CTX_DATA_O,
	input wire CTX_DONE_I,
	input wire CRX_VALID_I,
	input wire [7:0] CRX_ID_I,
	input wire [15:0] CRX_DATA_I,
	output wire RELAY_O,
	output wire [7:0] RELAY_ID_O,
	output wire [15:0] RADIO_RETRY_O,
	output wire [8:0] LED_O,
	output wire [15:0] BASE_OUT_O,
	input wire SRV_REQ_VALID_I,
	input wire [7:0] SRV_REQ_ID_I,
	input wire SRV_REQ_WRITE_I,
	input wire [15:0] SRV_REQ_ADDR_I,
	input wire [15:0] SRV_REQ_DATA_I,
	output wire SRV_RSP_VALID_O,
	output wire [15:0] SRV_RSP_DATA_O
);
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_INT = 5'h02;
	localparam [4:0] S_SEND = 5'h04;
	localparam [4:0] S_WAIT = 5'h08;
	localparam [4:0] S_DONE = 5'h10;
	localparam [31:0] TMO_RST = `MBD_TMO_RST_MS;

	reg [4:0] state_q;
	reg [4:0] state_d;
	reg [7:0] id_q;
	reg write_q;
	reg [15:0] addr_q;
	reg [15:0] wdata_q;
	reg [15:0] tmo_ms_q;
	reg [15:0] win_start_q;
	reg [15:0] win_count_q;
	reg [15:0] retry_q;
	reg [8:0] led_q;
	reg [15:0] base_out_q;
	reg [15:0] int_data_q;
	reg is_int_q;
	reg from_local_q;
	reg [15:0] bus_data_q;
	reg timed_out_q;
	reg rsp_valid_q;
	reg rsp_timeout_q;
	reg [15:0] rsp_data_q;
	reg relay_q;
	reg [7:0] relay_id_q;
	reg srv_rsp_valid_q;
	wire [7:0] base_id;
	wire is_internal;
	wire expired;
	wire local_en;
	wire srv_hit;
	wire [15:0] local_rdata;
	wire [15:0] srv_rdata;
	wire rsp_match;
	wire [15:0] led_idx;

	// true when an id falls in the radio's relay window
	function in_window;
		input [7:0] id;
		input [15:0] start;
		input [15:0] count;
		reg [16:0] last;
		begin
			last = {1'b0, start} + {1'b0, count};
			in_window = ({9'h000, id} >= {1'b0, start}) && ({9'h000, id} < last);
		end
	endfunction

	assign base_id = BASE_ID_SEL_I ? `MBD_ID_BASE_B : `MBD_ID_BASE_A;
	// reserved ids served inside, all else goes out on the wire
	assign is_internal = (CMD_ID_I == `MBD_ID_RADIO) ||
		(CMD_ID_I == `MBD_ID_LOCAL) ||
		(CMD_ID_I == `MBD_ID_LCD) ||
		(CMD_ID_I == base_id);

	assign CMD_READY_O = (state_q == S_IDLE);
	assign led_idx = addr_q - `MBD_LED_FIRST;
	assign rsp_match = CRX_VALID_I && (CRX_ID_I == id_q);

	// one engine, one request in flight
	always @* begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				if (CMD_VALID_I) begin
					state_d = is_internal ? S_INT : S_SEND;
				end
			end
			S_INT: begin
				state_d = S_DONE;
			end
			S_SEND: begin
				if (CTX_DONE_I) begin
					state_d = S_WAIT;
				end
			end
			S_WAIT: begin
				if (rsp_match || expired) begin
					state_d = S_DONE;
				end
			end
			S_DONE: begin
				state_d = S_IDLE;
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
	end

	always @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			state_q <= S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// latch the accepted request
	always @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			id_q <= 8'h00;
			write_q <= 1'b0;
			addr_q <= 16'h0000;
			wdata_q <= 16'h0000;
		end else if (state_q == S_IDLE && CMD_VALID_I) begin
			id_q <= CMD_ID_I;
			write_q <= CMD_WRITE_I;
			addr_q <= CMD_ADDR_I;
			wdata_q <= CMD_DATA_I;
		end
	end

	// timeout setting
	always @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			tmo_ms_q <= TMO_RST[15:0];
		end else if (TMO_LOAD_I) begin
			tmo_ms_q <= TMO_MS_I;
		end
	end
	assign TMO_MS_O = tmo_ms_q;

	mbd_timeout #(
		.MS_CYCLES(MS_CYCLES)
	) u_timeout (
		.clk_i(CORE_CLK_I),
		.nrst_i(NRST_I),
		.start_i(state_q == S_SEND && CTX_DONE_I),
		.run_i(state_q == S_WAIT),
		.limit_ms_i(tmo_ms_q),
		.expired_o(expired)
	);

	// internal targets: radio, display, base board
	always @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			win_start_q <= `MBD_WIN_START_RST;
			win_count_q <= `MBD_WIN_COUNT_RST;
			retry_q <= `MBD_RETRY_RST;
			led_q <= 9'h000;
			base_out_q <= 16'h0000;
			int_data_q <= 16'h0000;
			from_local_q <= 1'b0;
		end else if (state_q == S_INT) begin
			from_local_q <= (id_q == `MBD_ID_LOCAL);
			int_data_q <= 16'h0000;
			if (id_q == `MBD_ID_RADIO) begin
				case (addr_q)
					`MBD_REG_WIN_START: begin
						int_data_q <= win_start_q;
						if (write_q) begin
							win_start_q <= wdata_q;
						end
					end
					`MBD_REG_WIN_COUNT: begin
						int_data_q <= win_count_q;
						if (write_q) begin
							win_count_q <= (wdata_q > `MBD_WIN_COUNT_MAX) ?
								`MBD_WIN_COUNT_MAX : wdata_q;
						end
					end
					`MBD_REG_RETRY: begin
						int_data_q <= retry_q;
						if (write_q) begin
							retry_q <= wdata_q;
						end
					end
					default: begin
						int_data_q <= 16'h0000;
					end
				endcase
			end else if (id_q == `MBD_ID_LCD) begin
				if (addr_q >= `MBD_LED_FIRST && addr_q <= `MBD_LED_LAST) begin
					int_data_q <= {15'h0000, led_q[led_idx[3:0]]};
					if (write_q) begin
						led_q[led_idx[3:0]] <= wdata_q[0];
					end
				end
			end else if (id_q == base_id) begin
				int_data_q <= base_out_q;
				if (write_q) begin
					base_out_q <= wdata_q;
				end
			end
		end
	end
	assign RADIO_RETRY_O = retry_q;
	assign LED_O = led_q;
	assign BASE_OUT_O = base_out_q;

	// wire response capture
	always @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			bus_data_q <= 16'h0000;
			timed_out_q <= 1'b0;
		end else if (state_q == S_SEND) begin
			timed_out_q <= 1'b0;
		end else if (state_q == S_WAIT) begin
			if (rsp_match) begin
				bus_data_q <= CRX_DATA_I;
			end else if (expired) begin
				timed_out_q <= 1'b1;
				bus_data_q <= 16'h0000;
			end
		end
	end

	// answer to the command port
	always @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			rsp_valid_q <= 1'b0;
			rsp_timeout_q <= 1'b0;
			rsp_data_q <= 16'h0000;
		end else begin
			rsp_valid_q <= (state_q == S_DONE);
			if (state_q == S_DONE) begin
				if (from_local_q) begin
					rsp_data_q <= local_rdata;
					rsp_timeout_q <= 1'b0;
				end else if (is_int_q) begin
					rsp_data_q <= int_data_q;
					rsp_timeout_q <= 1'b0;
				end else begin
					rsp_data_q <= bus_data_q;
					rsp_timeout_q <= timed_out_q;
				end
			end
		end
	end
	assign RSP_VALID_O = rsp_valid_q;
	assign RSP_TIMEOUT_O = rsp_timeout_q;
	assign RSP_DATA_O = rsp_data_q;

	always @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			is_int_q <= 1'b0;
		end else if (state_q == S_IDLE && CMD_VALID_I) begin
			is_int_q <= is_internal;
		end
	end

	// client bus outputs
	assign CTX_VALID_O = (state_q == S_SEND);
	assign CTX_ID_O = id_q;
	assign CTX_WRITE_O = write_q;
	assign CTX_ADDR_O = addr_q;
	assign CTX_DATA_O = wdata_q;

	// radio watches each sent request
	always @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			relay_q <= 1'b0;
			relay_id_q <= 8'h00;
		end else begin
			relay_q <= (state_q == S_SEND) && CTX_DONE_I &&
				in_window(id_q, win_start_q, win_count_q);
			if (state_q == S_SEND && CTX_DONE_I) begin
				relay_id_q <= id_q;
			end
		end
	end
	assign RELAY_O = relay_q;
	assign RELAY_ID_O = relay_id_q;

	// server port: own id only, local store only
	assign srv_hit = SRV_REQ_VALID_I && (SRV_REQ_ID_I == HOST_FACING_SERVER_ID_I) &&
		(HOST_FACING_SERVER_ID_I >= `MBD_SRV_ID_MIN) &&
		(HOST_FACING_SERVER_ID_I <= `MBD_SRV_ID_MAX);
	assign local_en = (state_q == S_INT) && (id_q == `MBD_ID_LOCAL);

	always @(posedge CORE_CLK_I) begin
		if (!NRST_I) begin
			srv_rsp_valid_q <= 1'b0;
		end else begin
			srv_rsp_valid_q <= srv_hit;
		end
	end
	assign SRV_RSP_VALID_O = srv_rsp_valid_q;
	assign SRV_RSP_DATA_O = srv_rdata;

	mbd_regstore u_store (
		.clk_i(CORE_CLK_I),
		.a_en_i(srv_hit),
		.a_we_i(SRV_REQ_WRITE_I),
		.a_addr_i(SRV_REQ_ADDR_I[7:0]),
		.a_wdata_i(SRV_REQ_DATA_I),
		.a_rdata_o(srv_rdata),
		.b_en_i(local_en),
		.b_we_i(write_q),
		.b_addr_i(addr_q[7:0]),
		.b_wdata_i(wdata_q),
		.b_rdata_o(local_rdata)
	);
endmodule

// >>> testbench/mbd_chk_sva.sv
`timescale 1ns/100ps
module mbd_chk_sva (
	input wire CORE_CLK_I,
	input wire NRST_I,
	input wire [7:0] HOST_FACING_SERVER_ID_I,
	input wire BASE_ID_SEL_I,
	input wire CMD_VALID_I,
	input wire CMD_READY_O,
	input wire [7:0] CMD_ID_I,
	input wire CMD_WRITE_I,
	input wire [15:0] CMD_ADDR_I,
	input wire [15:0] CMD_DATA_I,
	input wire CTX_WRITE_O,
	input wire [15:0] CTX_ADDR_O,
	input wire [15:0] CTX_DATA_O,
	input wire RSP_VALID_O,
	input wire RSP_TIMEOUT_O,
	input wire [15:0] TMO_MS_O,
	input wire CTX_VALID_O,
	input wire [7:0] CTX_ID_O,
	input wire RELAY_O,
	input wire [7:0] RELAY_ID_O,
	input wire SRV_REQ_VALID_I,
	input wire [7:0] SRV_REQ_ID_I,
	input wire SRV_RSP_VALID_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!NRST_I);
	wire take = CMD_VALID_I && CMD_READY_O;
	wire intl = CMD_ID_I == 8'h01 || CMD_ID_I == 8'hC7 || CMD_ID_I == 8'hC9
		|| CMD_ID_I == (BASE_ID_SEL_I ? 8'hCB : 8'hC8);
	wire hit = SRV_REQ_VALID_I && SRV_REQ_ID_I == HOST_FACING_SERVER_ID_I
		&& SRV_REQ_ID_I >= 8'h01 && SRV_REQ_ID_I <= 8'hF6;
	one_out_a: assert property (take |=> !CMD_READY_O)
		else $error("second request accepted while busy");
	int_rsp_a: assert property (take && intl |-> ##3 RSP_VALID_O && !RSP_TIMEOUT_O)
		else $error("internal answer late or flagged");
	int_nowire_a: assert property (take && intl |=> !CTX_VALID_O [*3])
		else $error("internal id sent on the wire");
	wire_id_a: assert property (take && !intl |=> CTX_VALID_O && CTX_ID_O == $past(CMD_ID_I))
		else $error("wire request id wrong");
	wire_fields_a: assert property (take && !intl |=> CTX_WRITE_O == $past(CMD_WRITE_I)
		&& CTX_ADDR_O == $past(CMD_ADDR_I) && CTX_DATA_O == $past(CMD_DATA_I))
		else $error("wire request fields wrong");
	rsp_free_a: assert property (RSP_VALID_O |-> CMD_READY_O ##1 !RSP_VALID_O)
		else $error("engine not free after answer");
	srv_ans_a: assert property (hit |=> SRV_RSP_VALID_O)
		else $error("server port did not answer");
	srv_quiet_a: assert property (!hit |=> !SRV_RSP_VALID_O)
		else $error("server port answered foreign id");
	srv_busy_a: assert property (hit && !CMD_READY_O |=> SRV_RSP_VALID_O)
		else $error("server port blocked by engine");
	relay_id_a: assert property (RELAY_O |-> RELAY_ID_O == $past(CTX_ID_O))
		else $error("relayed id wrong");
	tmo_rst_a: assert property ($rose(NRST_I) |-> TMO_MS_O == 16'h1388)
		else $error("timeout reset value wrong");
	cover property (take && intl);
	cover property (RELAY_O);
	cover property (RSP_VALID_O && RSP_TIMEOUT_O);
endmodule

// >>> testbench/mbd_wire_model.sv
`timescale 1ns/100ps
module mbd_wire_model (
	input wire clk_i,
	input wire mute_i,
	input wire [3:0] wait_i,
	input wire ctx_valid_i,
	input wire [7:0] ctx_id_i,
	output reg done_o,
	output reg crx_valid_o,
	output reg [7:0] crx_id_o,
	output reg [15:0] crx_data_o
);
	reg [7:0] id_q;
	initial begin
		done_o = 1'b0;
		crx_valid_o = 1'b0;
		crx_id_o = 8'h00;
		crx_data_o = 16'h0000;
		forever begin
			@(negedge clk_i);
			crx_valid_o = 1'b0;
			crx_id_o = ~crx_id_o;
			crx_data_o = ~crx_data_o;
			if (ctx_valid_i) begin
				repeat (wait_i) @(negedge clk_i);
				id_q = ctx_id_i;
				done_o = 1'b1;
				@(negedge clk_i);
				done_o = 1'b0;
				if (!mute_i) begin
					repeat (wait_i) @(negedge clk_i);
					crx_valid_o = 1'b1;
					crx_id_o = id_q;
					crx_data_o = {8'h5A, id_q};
				end
			end
		end
	end
endmodule

// >>> testbench/mbd_top_tb.sv
`timescale 1ns/100ps
module mbd_top_tb;
	reg CORE_CLK_I = 1'b0;
	reg NRST_I, BASE_ID_SEL_I, TMO_LOAD_I, CMD_VALID_I, CMD_WRITE_I;
	reg SRV_REQ_VALID_I, SRV_REQ_WRITE_I, mute, to;
	reg [3:0] dly;
	reg [7:0] HOST_FACING_SERVER_ID_I, CMD_ID_I, SRV_REQ_ID_I;
	reg [15:0] TMO_MS_I, CMD_ADDR_I, CMD_DATA_I, SRV_REQ_ADDR_I, SRV_REQ_DATA_I, rd;
	wire CMD_READY_O, RSP_VALID_O, RSP_TIMEOUT_O, CTX_VALID_O, CTX_WRITE_O, CTX_DONE_I;
	wire CRX_VALID_I, RELAY_O, SRV_RSP_VALID_O;
	wire [7:0] CTX_ID_O, CRX_ID_I, RELAY_ID_O;
	wire [8:0] LED_O;
	wire [15:0] TMO_MS_O, RSP_DATA_O, CTX_ADDR_O, CTX_DATA_O, CRX_DATA_I;
	wire [15:0] RADIO_RETRY_O, BASE_OUT_O, SRV_RSP_DATA_O;
	integer err_count, num_checks, relays, r0, n;
	mbd_top #(.MS_CYCLES(10)) mbd_top_inst (.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I),
		.HOST_FACING_SERVER_ID_I(HOST_FACING_SERVER_ID_I), .BASE_ID_SEL_I(BASE_ID_SEL_I),
		.TMO_LOAD_I(TMO_LOAD_I), .TMO_MS_I(TMO_MS_I), .TMO_MS_O(TMO_MS_O),
		.CMD_VALID_I(CMD_VALID_I), .CMD_READY_O(CMD_READY_O), .CMD_ID_I(CMD_ID_I),
		.CMD_WRITE_I(CMD_WRITE_I), .CMD_ADDR_I(CMD_ADDR_I), .CMD_DATA_I(CMD_DATA_I),
		.RSP_VALID_O(RSP_VALID_O), .RSP_TIMEOUT_O(RSP_TIMEOUT_O), .RSP_DATA_O(RSP_DATA_O),
		.CTX_VALID_O(CTX_VALID_O), .CTX_ID_O(CTX_ID_O), .CTX_WRITE_O(CTX_WRITE_O),
		.CTX_ADDR_O(CTX_ADDR_O), .CTX_DATA_O(CTX_DATA_O), .CTX_DONE_I(CTX_DONE_I),
		.CRX_VALID_I(CRX_VALID_I), .CRX_ID_I(CRX_ID_I), .CRX_DATA_I(CRX_DATA_I),
		.RELAY_O(RELAY_O), .RELAY_ID_O(RELAY_ID_O), .RADIO_RETRY_O(RADIO_RETRY_O),
		.LED_O(LED_O), .BASE_OUT_O(BASE_OUT_O), .SRV_REQ_VALID_I(SRV_REQ_VALID_I),
		.SRV_REQ_ID_I(SRV_REQ_ID_I), .SRV_REQ_WRITE_I(SRV_REQ_WRITE_I),
		.SRV_REQ_ADDR_I(SRV_REQ_ADDR_I), .SRV_REQ_DATA_I(SRV_REQ_DATA_I),
		.SRV_RSP_VALID_O(SRV_RSP_VALID_O), .SRV_RSP_DATA_O(SRV_RSP_DATA_O));
	mbd_wire_model mbd_wire_model_inst (.clk_i(CORE_CLK_I), .mute_i(mute), .wait_i(dly),
		.ctx_valid_i(CTX_VALID_O), .ctx_id_i(CTX_ID_O), .done_o(CTX_DONE_I),
		.crx_valid_o(CRX_VALID_I), .crx_id_o(CRX_ID_I), .crx_data_o(CRX_DATA_I));
	initial begin
		forever #20 CORE_CLK_I = ~CORE_CLK_I;
	end
	always @(negedge CORE_CLK_I) begin
		if (RELAY_O === 1'b1)
			relays = relays + 1;
	end
	task chk(input [15:0] got, input [15:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task cmd(input [7:0] id, input wr, input [15:0] a, input [15:0] d);
		begin
			while (CMD_READY_O !== 1'b1)
				@(negedge CORE_CLK_I);
			CMD_ID_I = id;
			CMD_WRITE_I = wr;
			CMD_ADDR_I = a;
			CMD_DATA_I = d;
			CMD_VALID_I = 1'b1;
			@(negedge CORE_CLK_I);
			CMD_VALID_I = 1'b0;
			n = 0;
			while (RSP_VALID_O !== 1'b1 && n < 200) begin
				@(negedge CORE_CLK_I);
				n = n + 1;
			end
			chk({15'h0000, n >= 200}, 16'h0000);
			rd = RSP_DATA_O;
			to = RSP_TIMEOUT_O;
		end
	endtask
	task wrd(input [7:0] id, input rel);
		begin
			r0 = relays;
			cmd(id, 1'b0, 16'h0010, 16'h0000);
			chk(rd, {8'h5A, id});
			chk({15'h0000, relays != r0}, {15'h0000, rel});
		end
	endtask
	task srv(input [7:0] id, input wr, input [15:0] d, input [15:0] exp);
		begin
			SRV_REQ_ID_I = id;
			SRV_REQ_WRITE_I = wr;
			SRV_REQ_ADDR_I = 16'h0005;
			SRV_REQ_DATA_I = d;
			SRV_REQ_VALID_I = 1'b1;
			@(negedge CORE_CLK_I);
			SRV_REQ_VALID_I = 1'b0;
			chk(SRV_RSP_VALID_O === 1'b1 ? SRV_RSP_DATA_O : 16'hDEAD, exp);
		end
	endtask
	task stop_test;
		begin
			$display("checks=%0d errors=%0d", num_checks, err_count);
			if (err_count == 0 && num_checks > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial begin
		#200000;
		err_count = err_count + 1;
		stop_test;
	end
	initial begin
		{err_count, num_checks, relays, r0, n} = 0;
		{NRST_I, BASE_ID_SEL_I, TMO_LOAD_I, CMD_VALID_I, CMD_WRITE_I, mute} = 6'h00;
		{SRV_REQ_VALID_I, SRV_REQ_WRITE_I, CMD_ID_I, SRV_REQ_ID_I} = 18'h00000;
		{TMO_MS_I, CMD_ADDR_I, CMD_DATA_I, SRV_REQ_ADDR_I, SRV_REQ_DATA_I} = 80'h0;
		HOST_FACING_SERVER_ID_I = 8'h07;
		dly = 4'h1;
		repeat (8) @(negedge CORE_CLK_I);
		NRST_I = 1'b1;
		chk(TMO_MS_O, 16'h1388);
		chk(RADIO_RETRY_O, 16'h0008);
		chk({7'h00, LED_O}, 16'h0000);
		$display("reset test done");
		cmd(8'h01, 1'b0, 16'h1966, 16'h0000);
		chk(rd, 16'h000B);
		cmd(8'h01, 1'b0, 16'h1967, 16'h0000);
		chk(rd, 16'h0032);
		wrd(8'h05, 1'b0);
		wrd(8'h0A, 1'b0);
		wrd(8'h0B, 1'b1);
		wrd(8'h3C, 1'b1);
		wrd(8'h3D, 1'b0);
		cmd(8'h05, 1'b1, 16'h0020, 16'h5555);
		chk({15'h0000, to}, 16'h0000);
		cmd(8'h01, 1'b1, 16'h1966, 16'h0014);
		cmd(8'h01, 1'b1, 16'h1967, 16'h00C8);
		cmd(8'h01, 1'b0, 16'h1967, 16'h0000);
		chk(rd, 16'h0064);
		wrd(8'h0B, 1'b0);
		wrd(8'h77, 1'b1);
		wrd(8'h78, 1'b0);
		cmd(8'h01, 1'b1, 16'h177C, 16'h0003);
		chk(RADIO_RETRY_O, 16'h0003);
		$display("radio test done");
		cmd(8'hC7, 1'b1, 16'h0005, 16'h1234);
		srv(8'h07, 1'b1, 16'hBEEF, 16'h1234);
		cmd(8'hC7, 1'b0, 16'h0005, 16'h0000);
		chk(rd, 16'hBEEF);
		srv(8'h08, 1'b0, 16'h0000, 16'hDEAD);
		HOST_FACING_SERVER_ID_I = 8'hF6;
		srv(8'hF6, 1'b0, 16'h0000, 16'hBEEF);
		$display("store test done");
		cmd(8'hC9, 1'b1, 16'h044E, 16'h0001);
		cmd(8'hC9, 1'b1, 16'h0456, 16'h0001);
		chk({7'h00, LED_O}, 16'h0101);
		cmd(8'hC8, 1'b1, 16'h0000, 16'h00AB);
		chk(BASE_OUT_O, 16'h00AB);
		BASE_ID_SEL_I = 1'b1;
		cmd(8'hCB, 1'b1, 16'h0000, 16'h00CD);
		chk(BASE_OUT_O, 16'h00CD);
		wrd(8'hC8, 1'b0);
		$display("board test done");
		TMO_MS_I = 16'h0003;
		TMO_LOAD_I = 1'b1;
		@(negedge CORE_CLK_I);
		TMO_LOAD_I = 1'b0;
		chk(TMO_MS_O, 16'h0003);
		mute = 1'b1;
		fork
			cmd(8'h09, 1'b0, 16'h0010, 16'h0000);
			begin
				repeat (6) @(negedge CORE_CLK_I);
				srv(8'hF6, 1'b0, 16'h0000, 16'hBEEF);
			end
		join
		chk({15'h0000, to}, 16'h0001);
		chk({15'h0000, n >= 30 && n <= 40}, 16'h0001);
		mute = 1'b0;
		dly = 4'h6;
		wrd(8'h09, 1'b0);
		$display("timeout test done");
		stop_test;
	end
endmodule
bind mbd_top mbd_chk_sva mbd_chk_sva_inst (.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I),
	.HOST_FACING_SERVER_ID_I(HOST_FACING_SERVER_ID_I), .BASE_ID_SEL_I(BASE_ID_SEL_I),
	.CMD_VALID_I(CMD_VALID_I), .CMD_READY_O(CMD_READY_O), .CMD_ID_I(CMD_ID_I),
	.CMD_WRITE_I(CMD_WRITE_I), .CMD_ADDR_I(CMD_ADDR_I), .CMD_DATA_I(CMD_DATA_I),
	.CTX_WRITE_O(CTX_WRITE_O), .CTX_ADDR_O(CTX_ADDR_O), .CTX_DATA_O(CTX_DATA_O),
	.RSP_VALID_O(RSP_VALID_O), .RSP_TIMEOUT_O(RSP_TIMEOUT_O), .TMO_MS_O(TMO_MS_O),
	.CTX_VALID_O(CTX_VALID_O), .CTX_ID_O(CTX_ID_O), .RELAY_O(RELAY_O),
	.RELAY_ID_O(RELAY_ID_O), .SRV_REQ_VALID_I(SRV_REQ_VALID_I),
	.SRV_REQ_ID_I(SRV_REQ_ID_I), .SRV_RSP_VALID_O(SRV_RSP_VALID_O));
